// File: common/masc_pkg.sv
// Shared constants for the multiplexed converter serial control block
package masc_pkg;
  // Converter and input word
  localparam int DATA_BITS = 12;
  localparam int WORD_BITS = 4;
  localparam int WORD_EN_POS = 3;
  localparam int CODE_BITS = 3;
  localparam int CHANNELS_SMALL = 4;
  localparam int CHANNELS_LARGE = 8;
  // Timing at the 25 MHz system clock
  localparam int CLOCK_PERIOD_NS = 40;
  localparam int SWITCH_CLOSE_NS = 1000;
  localparam int SWITCH_CLOSE_CYCLES_RAW = (SWITCH_CLOSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int SWITCH_CLOSE_CYCLES = (SWITCH_CLOSE_CYCLES_RAW < 1) ? 1 : SWITCH_CLOSE_CYCLES_RAW;
  localparam int DLY_BITS = 8;
  // Shift clock falling edges counted from converter select low
  localparam logic [3:0] NULL_FALL = 4'h1;
  localparam logic [3:0] HOLD_FALL = 4'h2;
  // Register port
  localparam int ADDR_BITS = 4;
  localparam logic [3:0] REG_CTRL_ADDR = 4'h0;
  localparam logic [3:0] REG_STATUS_ADDR = 4'h4;
  localparam logic [3:0] REG_RESULT_ADDR = 4'h8;
  localparam int CTRL_SHARED_POS = 0;
  localparam logic CTRL_RESET = 1'b0;
  localparam int STAT_CHAN_POS = 0;
  localparam int STAT_WORD_POS = 8;
  localparam int STAT_POWER_POS = 12;
  localparam int STAT_BUSY_POS = 13;
  localparam logic [11:0] RESULT_RESET = 12'h000;
  // Converter sequence
  typedef enum logic [1:0] {
    CONV_IDLE,
    CONV_SAMPLE,
    CONV_RUN,
    CONV_REPLAY
  } masc_conv_type;
endpackage : masc_pkg

// File: design/masc_sar.sv
// Successive approximation register for the 12-bit converter
`timescale 1ns/100ps
`default_nettype none
module masc_sar #(
  parameter int WIDTH = masc_pkg::DATA_BITS
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control
  input wire logic start,
  input wire logic step,
  input wire logic abort,
  input wire logic cmp_above,
  // Results
  output logic [WIDTH-1:0] dac_code,
  output logic done
);
  import masc_pkg::*;

  localparam int IDX_BITS = $clog2(WIDTH);

  logic [WIDTH-1:0] code_q, code_d;
  logic [IDX_BITS-1:0] idx_q, idx_d;
  logic busy_q, busy_d;
  logic done_q, done_d;

  if (WIDTH < 2) begin : g_bad_width
    $error("masc_sar: WIDTH must be at least 2");
  end

  always_comb begin
    code_d = code_q;
    idx_d = idx_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (abort) begin
      busy_d = 1'b0;
    end else if (start) begin
      code_d = '0;
      code_d[WIDTH-1] = 1'b1;
      idx_d = IDX_BITS'(WIDTH - 1);
      busy_d = 1'b1;
    end else if (busy_q && step) begin
      // Keep the trial bit only while the held input is at or above it
      code_d[idx_q] = cmp_above;
      if (idx_q == '0) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end else begin
        code_d[idx_q - 1'b1] = 1'b1;
        idx_d = idx_q - 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      code_q <= '0;
      idx_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      code_q <= code_d;
      idx_q <= idx_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign dac_code = code_q;
  assign done = done_q;
endmodule : masc_sar
`default_nettype wire

// File: design/masc_core.sv
// Serial control of a multiplexed 12-bit sampling converter
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - the three word bits after the enable flag pick the channel.
// - enable low switches all channels off; high turns on the coded channel.
// - four-channel build decodes codes 0..3 only; eight-channel build decodes all.
// - conversion is measured against the negative input, not ground.
// - result is plain unipolar binary, zero volts gives all zeros.
// - on a shared wire the device drives it by the 6th falling edge.
// - multiplexer and converter selects act independently; channel stays loaded.
// - power only while select low; comparator and reference off after conversion.
// - after conversion the result repeats least significant bit first, then zeros.
// - select high keeps the converter off while words shift in.
// - sampling opens after switch delay, closes at second falling edge.
// - that falling edge starts hold and a 12-cycle conversion.
// - sampling lasts at least one and a half shift periods.
// - the enable flag is the first bit of the four-bit word.
// - while select high, bits taken on rising edges; last four kept.
// - data changes on falling edges and is captured on rising edges.
// - one null bit precedes the result on the serial output; here the pin stays low two shift periods before the most significant bit.
module masc_core #(
  parameter int CHANNELS = masc_pkg::CHANNELS_LARGE,
  parameter int SWITCH_CYCLES = masc_pkg::SWITCH_CLOSE_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Serial port from the host
  input wire logic shift_clk,
  input wire logic selector_choose_n,
  input wire logic converter_choose_n,
  input wire logic data_in,
  // Data pin, two-way when the wire is shared
  input wire logic data_pin_in,
  output logic data_pin_out,
  output logic data_pin_oe,
  // Analog front end control
  output logic [CHANNELS-1:0] chan_on,
  output logic sample_on,
  output logic hold_on,
  output logic cap_on_negative,
  output logic bias_power,
  output logic ref_connect,
  output logic [masc_pkg::DATA_BITS-1:0] dac_code,
  input wire logic cmp_above,
  // Register port
  input wire logic [masc_pkg::ADDR_BITS-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata
);
  import masc_pkg::*;

  if (CHANNELS != CHANNELS_SMALL && CHANNELS != CHANNELS_LARGE) begin : g_bad_channels
    $error("masc_core: CHANNELS must be 4 or 8");
  end
  if (SWITCH_CYCLES < 1 || SWITCH_CYCLES > 255) begin : g_bad_delay
    $error("masc_core: SWITCH_CYCLES must be 1 to 255");
  end

  // Edge detection of the host pins
  logic shift_prev_q, shift_prev_d;
  logic sel_prev_q, sel_prev_d;
  logic conv_prev_q, conv_prev_d;
  // Multiplexer side
  logic [WORD_BITS-1:0] in_word_q, in_word_d;
  logic [WORD_BITS-1:0] chan_word_q, chan_word_d;
  logic [CHANNELS-1:0] chan_on_q, chan_on_d;
  logic [DLY_BITS-1:0] mux_dly_q, mux_dly_d;
  logic mux_wait_q, mux_wait_d;
  // Converter side
  masc_conv_type conv_q, conv_d;
  logic [DLY_BITS-1:0] smp_dly_q, smp_dly_d;
  logic [3:0] falls_q, falls_d;
  logic [3:0] out_idx_q, out_idx_d;
  logic sample_q, sample_d;
  logic hold_q, hold_d;
  logic power_q, power_d;
  logic ref_q, ref_d;
  logic dout_q, dout_d;
  logic doe_q, doe_d;
  logic [DATA_BITS-1:0] result_q, result_d;
  // Registers
  logic shared_q, shared_d;
  logic [31:0] rdata_q, rdata_d;

  logic shift_rise, shift_fall, sel_fall, conv_fall;
  logic serial_bit;
  logic sar_start, sar_step, sar_abort, sar_done;
  logic [DATA_BITS-1:0] sar_code;
  logic [CHANNELS-1:0] decoded;

  assign shift_rise = shift_clk & ~shift_prev_q;
  assign shift_fall = ~shift_clk & shift_prev_q;
  assign sel_fall = sel_prev_q & ~selector_choose_n;
  assign conv_fall = conv_prev_q & ~converter_choose_n;
  // Shared wire takes the word from the data pin itself
  assign serial_bit = shared_q ? data_pin_in : data_in;

  // One decoder leg per channel
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_decode
    assign decoded[ch] = chan_word_q[WORD_EN_POS]
      && (chan_word_q[CODE_BITS-1:0] == CODE_BITS'(ch));
  end

  masc_sar #(
    .WIDTH(DATA_BITS)
  ) u_sar (
    .clock(clock),
    .rst(rst),
    .start(sar_start),
    .step(sar_step),
    .abort(sar_abort),
    .cmp_above(cmp_above),
    .dac_code(sar_code),
    .done(sar_done)
  );

  always_comb begin
    shift_prev_d = shift_clk;
    sel_prev_d = selector_choose_n;
    conv_prev_d = converter_choose_n;
    in_word_d = in_word_q;
    chan_word_d = chan_word_q;
    chan_on_d = chan_on_q;
    mux_dly_d = mux_dly_q;
    mux_wait_d = mux_wait_q;
    conv_d = conv_q;
    smp_dly_d = smp_dly_q;
    falls_d = falls_q;
    out_idx_d = out_idx_q;
    sample_d = sample_q;
    hold_d = hold_q;
    power_d = power_q;
    ref_d = ref_q;
    dout_d = dout_q;
    doe_d = doe_q;
    result_d = result_q;
    sar_start = 1'b0;
    sar_step = 1'b0;
    sar_abort = 1'b0;

    // Word shifts in only while the selector select is high
    if (selector_choose_n && shift_rise) begin
      in_word_d = {in_word_q[WORD_BITS-2:0], serial_bit};
    end
    // Break before make: all off, then the new channel after the delay
    if (sel_fall) begin
      chan_word_d = in_word_q;
      chan_on_d = '0;
      mux_dly_d = DLY_BITS'(SWITCH_CYCLES);
      mux_wait_d = 1'b1;
    end else if (mux_wait_q) begin
      if (mux_dly_q > DLY_BITS'(1)) begin
        mux_dly_d = mux_dly_q - 1'b1;
      end else begin
        mux_wait_d = 1'b0;
        chan_on_d = decoded;
      end
    end

    unique case (conv_q)
      CONV_IDLE: begin
        if (conv_fall) begin
          conv_d = CONV_SAMPLE;
          power_d = 1'b1;
          ref_d = 1'b1;
          smp_dly_d = DLY_BITS'(SWITCH_CYCLES);
          falls_d = '0;
        end
      end
      CONV_SAMPLE: begin
        if (smp_dly_q != '0) begin
          smp_dly_d = smp_dly_q - 1'b1;
        end else if (falls_q < HOLD_FALL) begin
          sample_d = 1'b1;
        end
        if (shift_fall) begin
          falls_d = falls_q + 1'b1;
          if (falls_q + 1'b1 == NULL_FALL) begin
            doe_d = 1'b1;
            dout_d = 1'b0;
          end
          // Second falling edge is a full period plus the half before it
          if (falls_q + 1'b1 == HOLD_FALL) begin
            sample_d = 1'b0;
            hold_d = 1'b1;
            sar_start = 1'b1;
            conv_d = CONV_RUN;
          end
        end
      end
      CONV_RUN: begin
        if (shift_fall) begin
          sar_step = 1'b1;
          dout_d = cmp_above;
        end
        if (sar_done) begin
          result_d = sar_code;
          power_d = 1'b0;
          ref_d = 1'b0;
          hold_d = 1'b0;
          out_idx_d = 4'h1;
          conv_d = CONV_REPLAY;
        end
      end
      CONV_REPLAY: begin
        // Bit 0 already sits on the pin; replay continues from bit 1
        if (shift_fall) begin
          if (out_idx_q < 4'(DATA_BITS)) begin
            dout_d = result_q[out_idx_q];
            out_idx_d = out_idx_q + 1'b1;
          end else begin
            dout_d = 1'b0;
          end
        end
      end
    endcase

    // Select high ends the exchange at once and keeps the converter off
    if (converter_choose_n) begin
      conv_d = CONV_IDLE;
      power_d = 1'b0;
      ref_d = 1'b0;
      sample_d = 1'b0;
      hold_d = 1'b0;
      doe_d = 1'b0;
      dout_d = 1'b0;
      sar_abort = 1'b1;
    end
  end

  // Register port: one control bit, status and the last result
  always_comb begin
    shared_d = shared_q;
    rdata_d = '0;
    if (reg_write && reg_addr == REG_CTRL_ADDR) begin
      shared_d = reg_wdata[CTRL_SHARED_POS];
    end
    if (reg_read) begin
      unique case (reg_addr)
        REG_CTRL_ADDR: rdata_d[CTRL_SHARED_POS] = shared_q;
        REG_STATUS_ADDR: begin
          rdata_d[STAT_CHAN_POS +: CHANNELS] = chan_on_q;
          rdata_d[STAT_WORD_POS +: WORD_BITS] = chan_word_q;
          rdata_d[STAT_POWER_POS] = power_q;
          rdata_d[STAT_BUSY_POS] = (conv_q != CONV_IDLE);
        end
        REG_RESULT_ADDR: rdata_d[DATA_BITS-1:0] = result_q;
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      shift_prev_q <= 1'b0;
      sel_prev_q <= 1'b1;
      conv_prev_q <= 1'b1;
      in_word_q <= '0;
      chan_word_q <= '0;
      chan_on_q <= '0;
      mux_dly_q <= '0;
      mux_wait_q <= 1'b0;
      conv_q <= CONV_IDLE;
      smp_dly_q <= '0;
      falls_q <= '0;
      out_idx_q <= '0;
      sample_q <= 1'b0;
      hold_q <= 1'b0;
      power_q <= 1'b0;
      ref_q <= 1'b0;
      dout_q <= 1'b0;
      doe_q <= 1'b0;
      result_q <= RESULT_RESET;
      shared_q <= CTRL_RESET;
      rdata_q <= '0;
    end else begin
      shift_prev_q <= shift_prev_d;
      sel_prev_q <= sel_prev_d;
      conv_prev_q <= conv_prev_d;
      in_word_q <= in_word_d;
      chan_word_q <= chan_word_d;
      chan_on_q <= chan_on_d;
      mux_dly_q <= mux_dly_d;
      mux_wait_q <= mux_wait_d;
      conv_q <= conv_d;
      smp_dly_q <= smp_dly_d;
      falls_q <= falls_d;
      out_idx_q <= out_idx_d;
      sample_q <= sample_d;
      hold_q <= hold_d;
      power_q <= power_d;
      ref_q <= ref_d;
      dout_q <= dout_d;
      doe_q <= doe_d;
      result_q <= result_d;
      shared_q <= shared_d;
      rdata_q <= rdata_d;
    end
  end

  assign data_pin_out = dout_q;
  assign data_pin_oe = doe_q;
  assign chan_on = chan_on_q;
  assign sample_on = sample_q;
  assign hold_on = hold_q;
  // Capacitor bottom plate goes to the negative input during hold
  assign cap_on_negative = hold_q;
  assign bias_power = power_q;
  assign ref_connect = ref_q;
  assign dac_code = sar_code;
  assign reg_rdata = rdata_q;
endmodule : masc_core
`default_nettype wire

// File: verification/masc_monitor.sv
// Concurrent checks on the converter serial control ports
`timescale 1ns/100ps
`default_nettype none
module masc_monitor #(
  parameter int CHANNELS = 8
) (
  // Clock, reset and serial port
  input wire logic clock,
  input wire logic rst,
  input wire logic shift_clk,
  input wire logic converter_choose_n,
  input wire logic data_pin_out,
  input wire logic data_pin_oe,
  // Front end
  input wire logic [CHANNELS-1:0] chan_on,
  input wire logic sample_on,
  input wire logic hold_on,
  input wire logic cap_on_negative,
  input wire logic bias_power,
  input wire logic ref_connect
);
  logic sh_q;
  logic [3:0] fall_q;
  logic [4:0] hold_falls_q;
  wire logic fall = sh_q & ~shift_clk;
  always_ff @(posedge clock) begin
    sh_q <= shift_clk;
    fall_q <= {fall_q[2:0], fall};
    if (rst || !hold_on) begin
      hold_falls_q <= 5'h00;
    end else if (fall) begin
      hold_falls_q <= hold_falls_q + 5'h01;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_oe_released: assert property (converter_choose_n [*4] |-> !data_pin_oe)
    else $error("data pin driven while deselected");
  a_idle_power: assert property (converter_choose_n [*4] |-> !bias_power && !ref_connect && !hold_on && !sample_on)
    else $error("converter powered while deselected");
  a_hold_powered: assert property (hold_on |-> bias_power && ref_connect)
    else $error("conversion without power");
  a_power_drop: assert property ($fell(hold_on) |-> !bias_power && !ref_connect)
    else $error("converter still powered after conversion");
  a_hold_negative: assert property (hold_on == cap_on_negative)
    else $error("capacitor not on negative input in hold");
  a_chan_single: assert property ($onehot0(chan_on))
    else $error("more than one channel on");
  a_sample_hold_apart: assert property (!(sample_on && hold_on))
    else $error("sample and hold together");
  a_hold_at_fall: assert property ($rose(hold_on) |-> |fall_q)
    else $error("hold not started by a falling edge");
  a_conv_length: assert property ($fell(hold_on) && !converter_choose_n |-> hold_falls_q == 5'h0C)
    else $error("conversion not 12 shift cycles");
  a_dout_on_fall: assert property ($changed(data_pin_out) && $past(data_pin_oe) && !converter_choose_n |-> |fall_q)
    else $error("serial output changed off a falling edge");
  a_sample_selected: assert property ($rose(sample_on) |-> !converter_choose_n && bias_power)
    else $error("sampling opened while deselected");
endmodule : masc_monitor
bind masc_core masc_monitor #(.CHANNELS(CHANNELS)) masc_monitor_i (
  .clock(clock), .rst(rst), .shift_clk(shift_clk), .converter_choose_n(converter_choose_n),
  .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe), .chan_on(chan_on), .sample_on(sample_on),
  .hold_on(hold_on), .cap_on_negative(cap_on_negative), .bias_power(bias_power), .ref_connect(ref_connect)
);
`default_nettype wire

// File: verification/masc_host_model.sv
// Host serial master: shift clock, both selects and data bit
`timescale 1ns/100ps
`default_nettype none
module masc_host_model #(
  parameter int HALF = 40
) (
  // Pacing and observation
  input wire logic clock,
  input wire logic shared,
  input wire logic wire_in,
  input wire logic dev_oe,
  // Serial port
  output logic shift_clk,
  output logic selector_choose_n,
  output logic converter_choose_n,
  output logic host_bit,
  output logic host_oe
);
  initial begin
    shift_clk = 1'b0;
    selector_choose_n = 1'b1;
    converter_choose_n = 1'b1;
    host_bit = 1'b0;
    host_oe = 1'b0;
  end
  // Half period of 40 cycles keeps the shift clock at 312.5 kHz
  task automatic xfer(input logic [7:0] pat, input int nb, input logic mux, input logic adc, input int nclk,
                      output logic [31:0] rx, output logic [31:0] oe);
    rx = '0;
    oe = '0;
    host_oe <= shared;
    for (int i = nb - 1; i >= 0; i--) begin
      host_bit <= pat[i];
      repeat (HALF) @(posedge clock);
      shift_clk <= 1'b1;
      repeat (HALF) @(posedge clock);
      shift_clk <= 1'b0;
    end
    host_oe <= 1'b0;
    if (mux) selector_choose_n <= 1'b0;
    if (adc) converter_choose_n <= 1'b0;
    for (int k = 0; k <= nclk; k++) begin
      repeat (HALF) @(posedge clock);
      if (k > 0) begin
        rx[k-1] = wire_in;
        oe[k-1] = dev_oe;
      end
      shift_clk <= 1'b1;
      repeat (HALF) @(posedge clock);
      shift_clk <= 1'b0;
    end
    selector_choose_n <= 1'b1;
    converter_choose_n <= 1'b1;
    repeat (HALF) @(posedge clock);
  endtask : xfer
endmodule : masc_host_model
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench for the converter serial control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import masc_pkg::*;
  logic clock, rst, shared, host_bit, host_oe, reg_write, reg_read;
  logic shift_clk, selector_choose_n, converter_choose_n, data_pin_out, data_pin_oe, sample_on, hold_on;
  logic [7:0] chan_on;
  logic [11:0] dac_code, held, r;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rx, oe, rd;
  int n_fail, checks_done, cycles;
  // Shared wire idles high through a pull-up
  wire logic wire_lvl = data_pin_oe ? data_pin_out : (host_oe ? host_bit : 1'b1);
  wire logic cmp_above = held >= dac_code;
  masc_core masc_core_i (.clock(clock), .rst(rst), .shift_clk(shift_clk), .selector_choose_n(selector_choose_n),
    .converter_choose_n(converter_choose_n), .data_in(host_bit), .data_pin_in(wire_lvl),
    .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe), .chan_on(chan_on), .sample_on(sample_on),
    .hold_on(hold_on), .cap_on_negative(), .bias_power(), .ref_connect(), .dac_code(dac_code),
    .cmp_above(cmp_above), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata));
  masc_host_model host_i (.clock(clock), .shared(shared), .wire_in(wire_lvl), .dev_oe(data_pin_oe),
    .shift_clk(shift_clk), .selector_choose_n(selector_choose_n), .converter_choose_n(converter_choose_n),
    .host_bit(host_bit), .host_oe(host_oe));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Extremes of each end of the span on channels 0 and 7
  function automatic logic [11:0] volt(input logic [2:0] c);
    return (c == 3'h0) ? 12'h000 : (c == 3'h7) ? 12'hFFF : 12'({9'h0, c} * 12'h1E3 + 12'h0A5);
  endfunction : volt
  function automatic logic [31:0] exp_rx(input logic [11:0] v);
    exp_rx = '0;
    for (int j = 0; j < 12; j++) exp_rx[2+j] = v[11-j];
    for (int j = 1; j < 12; j++) exp_rx[13+j] = v[j];
  endfunction : exp_rx
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (converter_choose_n) held <= 12'h000;
    else if (sample_on) for (int c = 0; c < 8; c++) if (chan_on[c]) held <= volt(3'(c));
    if (cycles == 70000) begin
      n_fail++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(posedge clock);
    d = reg_rdata;
  endtask : reg_rd
  task automatic run(input logic [7:0] pat, input int nb, input logic mux, input logic [3:0] w);
    host_i.xfer(pat, nb, mux, 1'b1, 27, rx, oe);
    r = w[3] ? volt(w[2:0]) : 12'h000;
    chk(rx & 32'h07FF_FFFD, exp_rx(r));
    reg_rd(REG_RESULT_ADDR, rd);
    chk(rd, {20'h0, r});
    reg_rd(REG_STATUS_ADDR, rd);
    chk(rd, {20'h0, w, w[3] ? (8'h01 << w[2:0]) : 8'h00});
  endtask : run
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  initial begin
    rst = 1'b1;
    shared = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    reg_rd(REG_CTRL_ADDR, rd);
    chk(rd, 32'h0);
    reg_rd(REG_RESULT_ADDR, rd);
    chk(rd, 32'h0);
    reg_rd(4'hC, rd);
    chk(rd, 32'h0);
    $display("registers after reset done");
    for (int c = 0; c < 8; c++) run({5'h01, 3'(c)}, 4, 1'b1, {1'b1, 3'(c)});
    run(8'h05, 4, 1'b1, 4'h5);
    run(8'h0E, 6, 1'b1, 4'hE);
    $display("channel decode done");
    host_i.xfer(8'h0D, 4, 1'b1, 1'b0, 2, rx, oe);
    chk({24'h0, chan_on}, 32'h20);
    reg_wr(REG_STATUS_ADDR, 32'hFFFF);
    repeat (2) run(8'h00, 4, 1'b0, 4'hD);
    // Ones shifted in while converting address the next channel
    run(8'h0F, 4, 1'b0, 4'hD);
    host_i.xfer(8'h00, 0, 1'b1, 1'b0, 0, rx, oe);
    chk({24'h0, chan_on}, 32'h80);
    $display("separate selects done");
    // Host must see shared mode before its next transfer starts
    shared <= 1'b1;
    reg_wr(REG_CTRL_ADDR, 32'h1);
    run(8'h0B, 4, 1'b1, 4'hB);
    chk({31'h0, oe[5]}, 32'h1);
    reg_rd(REG_CTRL_ADDR, rd);
    chk(rd, 32'h1);
    $display("shared wire done");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
